// *** hdl/tcp_timer_unit.sv ***
/*
 * compare and pwm part of a 16-bit timer: compare-a and compare-p registers,
 * compare-match output, timer/counter and pwm modes, two sticky flags and
 * one output pin, reached over avalon-mm with waitrequest.
 * assumes timer_tick_i is a one-cycle strobe from the clock-select logic on
 * clk_i; the pin mux outside resolves tp_out_o with tp_oe_o.
 */
`default_nettype none

// Notes on behaviour
// - compare-a is 16 bits in writable low and high bytes, reset zero.
// - compare-p byte matches only the counter top byte, every 256 clocks.
// - compare mode, clear-select low: clear on p match, set a and p flags.
// - clear-select high: clear on a match, only the a flag is raised.
// - in compare mode the pin changes only on compare-a match.
// - output-action field sets high, low or toggles; zero leaves pin alone.
// - timer-on rising loads the pin with the initial-level bit.
// - timer/counter mode counts like compare mode but leaves the pin.
// - pwm mode ignores clear-select; one compare sets period, other duty.
// - swap low: clear on compare-p, duty is compare-a.
// - swap high: clear on compare-a, duty is compare-p times 256.
// - duty at or above period holds the pwm output active.
// - pwm mode sets a flag on a match and p flag on p match.
// - pwm: initial-level picks active level, action field, polarity inverts.
// - forced output levels leave pwm counting and matching running.
// - pwm action codes: 00 inactive, 01 active, 10 waveform.
// - timer-on rising zeroes counter; falling stops and keeps the count.
// - polarity inverts the pin, no effect in timer/counter mode.
module tcp_timer_unit (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic timer_tick_i,
	input wire logic [tcp_pkg::ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic tp_out_o,
	output logic tp_oe_o,
	output logic compare_a_flag_o,
	output logic compare_p_flag_o
);
	import tcp_pkg::*;

	// ------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------
	logic ack_q;
	logic wr_en;
	logic rd_en;
	logic [31:0] rdata_q;
	logic timer_on_q;
	logic on_prev_q;
	logic on_rise;
	logic [7:0] ctl_two_q;
	logic [7:0] cca_lo_q;
	logic [7:0] cca_hi_q;
	logic [7:0] ccp_q;
	logic [15:0] compare_a_value;
	logic [15:0] cnt_q;
	logic [15:0] cnt_next;
	logic a_match;
	logic p_match;
	logic clr_on_a;
	logic count_clr;
	logic a_evt;
	logic p_evt;
	logic a_flag_q;
	logic p_flag_q;
	logic out_q;
	logic pwm_act;
	logic pwm_lvl;
	logic pin_d;
	logic [16:0] period17;
	logic [16:0] duty17;
	tcp_mode_e mode;
	logic [1:0] io_sel;
	logic init_level;
	logic polarity;
	logic swap;
	logic clear_sel;

	// word-select decode, shared by the read mux and every write strobe
	function automatic logic sel(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
		sel = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
	endfunction : sel

	// ------------------------------------------------------------------
	// avalon-mm slave
	// ------------------------------------------------------------------
	// one wait cycle per access so read data can come from a flop
	assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
	assign wr_en = avs_write_i & ack_q & avs_byteenable_i[0];
	assign rd_en = avs_read_i & ~ack_q;
	assign avs_readdata_o = rdata_q;

	// handshake phase
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
			ack_q <= 1'b0;
		else
			ack_q <= (avs_read_i | avs_write_i) & ~ack_q;
	end

	// read mux, unmapped words read as zero
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
			rdata_q <= 32'h0000_0000;
		else if (rd_en)
		begin
			rdata_q <= 32'h0000_0000;
			if (sel(avs_address_i, OFF_CTRL_ON))
				rdata_q[BIT_TIMER_ON] <= timer_on_q;
			if (sel(avs_address_i, OFF_TIMER_CONTROL_TWO))
				rdata_q[7:0] <= ctl_two_q;
			if (sel(avs_address_i, OFF_COMPARE_A_LOW_BYTE))
				rdata_q[7:0] <= cca_lo_q;
			if (sel(avs_address_i, OFF_COMPARE_A_HIGH_BYTE))
				rdata_q[7:0] <= cca_hi_q;
			if (sel(avs_address_i, OFF_COMPARE_P_TOP_BYTE))
				rdata_q[7:0] <= ccp_q;
			if (sel(avs_address_i, OFF_STATUS))
			begin
				rdata_q[BIT_A_FLAG] <= a_flag_q;
				rdata_q[BIT_P_FLAG] <= p_flag_q;
				rdata_q[BIT_PIN] <= tp_out_o;
			end
		end
	end

	// ------------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			timer_on_q <= 1'b0;
			ctl_two_q <= RST_BYTE;
			cca_lo_q <= RST_BYTE;
			cca_hi_q <= RST_BYTE;
			ccp_q <= RST_BYTE;
		end
		else if (wr_en)
		begin
			if (sel(avs_address_i, OFF_CTRL_ON))
				timer_on_q <= avs_writedata_i[BIT_TIMER_ON];
			if (sel(avs_address_i, OFF_TIMER_CONTROL_TWO))
				ctl_two_q <= avs_writedata_i[7:0];
			if (sel(avs_address_i, OFF_COMPARE_A_LOW_BYTE))
				cca_lo_q <= avs_writedata_i[7:0];
			if (sel(avs_address_i, OFF_COMPARE_A_HIGH_BYTE))
				cca_hi_q <= avs_writedata_i[7:0];
			if (sel(avs_address_i, OFF_COMPARE_P_TOP_BYTE))
				ccp_q <= avs_writedata_i[7:0];
		end
	end

	assign mode = tcp_mode_e'(ctl_two_q[BIT_MODE_HI:BIT_MODE_LO]);
	assign io_sel = ctl_two_q[BIT_IO_HI:BIT_IO_LO];
	assign init_level = ctl_two_q[BIT_INIT_LEVEL];
	assign polarity = ctl_two_q[BIT_POLARITY];
	assign swap = ctl_two_q[BIT_SWAP];
	assign clear_sel = ctl_two_q[BIT_CLEAR_SEL];
	assign compare_a_value = {cca_hi_q, cca_lo_q};

	// ------------------------------------------------------------------
	// counter and comparators
	// ------------------------------------------------------------------
	// edge of the on bit, seen one cycle after the write lands
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
			on_prev_q <= 1'b0;
		else
			on_prev_q <= timer_on_q;
	end

	assign on_rise = timer_on_q & ~on_prev_q;
	assign cnt_next = cnt_q + 16'h0001;
	assign a_match = (cnt_next == compare_a_value);
	// zero in compare-p becomes a match on wrap, i.e. 65536 clocks
	assign p_match = (cnt_next == {ccp_q, 8'h00});

	// pwm swaps which comparator clears; other modes use clear-select
	assign clr_on_a = (mode == TCP_MODE_PWM) ? swap : clear_sel;
	assign count_clr = clr_on_a ? a_match : p_match;
	assign a_evt = timer_on_q & timer_tick_i & a_match;
	// p flag is suppressed when compare-a clears outside pwm
	assign p_evt = timer_on_q & timer_tick_i & p_match
		& ((mode == TCP_MODE_PWM) | ~clear_sel);

	// counting keeps going whatever the pin does
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
			cnt_q <= RST_COUNT;
		else if (on_rise)
			cnt_q <= RST_COUNT;
		else if (timer_on_q & timer_tick_i)
			cnt_q <= count_clr ? RST_COUNT : cnt_next;
	end

	// ------------------------------------------------------------------
	// sticky flags, write one to clear; a new match wins over the clear
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			a_flag_q <= 1'b0;
			p_flag_q <= 1'b0;
		end
		else if (mode != TCP_MODE_CAP)
		begin
			if (a_evt)
				a_flag_q <= 1'b1;
			else if (wr_en & sel(avs_address_i, OFF_STATUS) & avs_writedata_i[BIT_A_FLAG])
				a_flag_q <= 1'b0;
			if (p_evt)
				p_flag_q <= 1'b1;
			else if (wr_en & sel(avs_address_i, OFF_STATUS) & avs_writedata_i[BIT_P_FLAG])
				p_flag_q <= 1'b0;
		end
	end

	assign compare_a_flag_o = a_flag_q;
	assign compare_p_flag_o = p_flag_q;

	// ------------------------------------------------------------------
	// compare-match output level
	// ------------------------------------------------------------------
	// compare-a of zero cannot match before a full wrap, hence forbidden
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
			out_q <= 1'b0;
		else if (on_rise)
			out_q <= init_level;
		else if (a_evt & (mode == TCP_MODE_CMP))
		begin
			case (io_sel)
				IO_LOW: out_q <= 1'b0;
				IO_HIGH: out_q <= 1'b1;
				IO_TOGGLE: out_q <= ~out_q;
				default: out_q <= out_q;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// pwm waveform
	// ------------------------------------------------------------------
	assign period17 = swap ? {1'b0, compare_a_value}
		: ((ccp_q == 8'h00) ? 17'h1_0000 : {1'b0, ccp_q, 8'h00});
	assign duty17 = swap
		? ((ccp_q == 8'h00) ? 17'h1_0000 : {1'b0, ccp_q, 8'h00})
		: {1'b0, compare_a_value};
	assign pwm_act = (duty17 >= period17) | ({1'b0, cnt_q} < duty17);
	assign pwm_lvl = init_level ? pwm_act : ~pwm_act;

	// pin mux; single pulse code is out of scope and parks inactive
	always_comb
	begin
		pin_d = 1'b0;
		case (mode)
			TCP_MODE_CMP: pin_d = out_q ^ polarity;
			TCP_MODE_PWM:
			begin
				case (io_sel)
					IO_NONE: pin_d = ~init_level ^ polarity;
					IO_LOW: pin_d = init_level ^ polarity;
					IO_HIGH: pin_d = pwm_lvl ^ polarity;
					default: pin_d = ~init_level ^ polarity;
				endcase
			end
			default: pin_d = 1'b0;
		endcase
	end

	// registered pin keeps glitches off the pad
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			tp_out_o <= 1'b0;
			tp_oe_o <= 1'b0;
		end
		else
		begin
			tp_out_o <= pin_d;
			tp_oe_o <= (mode == TCP_MODE_CMP) | (mode == TCP_MODE_PWM);
		end
	end

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	answer_bound_a: assert property ((avs_read_i | avs_write_i) |-> ##[0:1] !avs_waitrequest_o)
		else $error("access not answered within one wait cycle");
	cca_reset_zero_a: assert property ($fell(sys_rst_i) |-> compare_a_value == 16'h0000)
		else $error("compare-a not zero after reset");
	p_clear_cmp_a: assert property ((mode == TCP_MODE_CMP) && !clear_sel && timer_on_q
		&& !on_rise && timer_tick_i && p_match |=> cnt_q == 16'h0000 && p_flag_q)
		else $error("p match did not clear counter and set p flag");
	no_p_flag_a: assert property ((mode == TCP_MODE_CMP) && clear_sel && !p_flag_q
		|=> !p_flag_q)
		else $error("p flag raised while compare-a clears");
	pin_holds_a: assert property ((mode == TCP_MODE_CMP) && !on_rise && !a_evt
		|=> out_q == $past(out_q))
		else $error("compare output moved without a match");
	toggle_on_a_a: assert property ((mode == TCP_MODE_CMP) && a_evt && !on_rise
		&& io_sel == IO_TOGGLE |=> out_q != $past(out_q))
		else $error("toggle action did not toggle");
	on_rise_load_a: assert property (on_rise |=> out_q == $past(init_level)
		&& cnt_q == 16'h0000)
		else $error("timer-on edge did not reload pin and counter");
	tmr_pin_off_a: assert property ((mode == TCP_MODE_TMR) ##1 (mode == TCP_MODE_TMR)
		|-> !tp_oe_o)
		else $error("pin driven in timer/counter mode");
	pwm_full_a: assert property ((mode == TCP_MODE_PWM) && io_sel == IO_HIGH
		&& duty17 >= period17 |=> tp_out_o == $past(init_level ^ polarity))
		else $error("pwm not held active at full duty");
	count_hold_a: assert property (!timer_on_q && !on_rise |=> $stable(cnt_q))
		else $error("counter moved while off");

	cmp_match_c: cover property ((mode == TCP_MODE_CMP) && a_evt);
	overflow_c: cover property (p_evt && ccp_q == 8'h00);
	pwm_wave_c: cover property ((mode == TCP_MODE_PWM) && io_sel == IO_HIGH && $rose(tp_out_o));

endmodule : tcp_timer_unit

`default_nettype wire

// *** hdl/tcp_pkg.sv ***
/*
 * package for the timer compare and pwm unit: register offsets, field
 * positions, reset values and mode codes.
 * assumes a 32-bit avalon-mm slave port with byte addresses, one word per
 * register, all fields in the low byte.
 */
`default_nettype none

package tcp_pkg;

	// ------------------------------------------------------------------
	// register map (byte offsets)
	// ------------------------------------------------------------------
	localparam int unsigned ADDR_W = 5;
	localparam logic [ADDR_W-1:0] OFF_CTRL_ON = 5'h00;
	localparam logic [ADDR_W-1:0] OFF_TIMER_CONTROL_TWO = 5'h04;
	localparam logic [ADDR_W-1:0] OFF_COMPARE_A_LOW_BYTE = 5'h08;
	localparam logic [ADDR_W-1:0] OFF_COMPARE_A_HIGH_BYTE = 5'h0c;
	localparam logic [ADDR_W-1:0] OFF_COMPARE_P_TOP_BYTE = 5'h10;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 5'h14;

	// ------------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------------
	localparam int unsigned BIT_TIMER_ON = 3;
	localparam int unsigned BIT_MODE_HI = 7;
	localparam int unsigned BIT_MODE_LO = 6;
	localparam int unsigned BIT_IO_HI = 5;
	localparam int unsigned BIT_IO_LO = 4;
	localparam int unsigned BIT_INIT_LEVEL = 3;
	localparam int unsigned BIT_POLARITY = 2;
	localparam int unsigned BIT_SWAP = 1;
	localparam int unsigned BIT_CLEAR_SEL = 0;
	localparam int unsigned BIT_A_FLAG = 0;
	localparam int unsigned BIT_P_FLAG = 1;
	localparam int unsigned BIT_PIN = 2;

	// ------------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------------
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_COUNT = 16'h0000;

	// ------------------------------------------------------------------
	// mode and output-action codes
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		TCP_MODE_CMP = 2'h0,
		TCP_MODE_CAP = 2'h1,
		TCP_MODE_PWM = 2'h2,
		TCP_MODE_TMR = 2'h3
	} tcp_mode_e;

	localparam logic [1:0] IO_NONE = 2'h0;   // compare: no change / pwm: inactive
	localparam logic [1:0] IO_LOW = 2'h1;    // compare: low / pwm: active
	localparam logic [1:0] IO_HIGH = 2'h2;   // compare: high / pwm: waveform
	localparam logic [1:0] IO_TOGGLE = 2'h3; // compare: toggle

endpackage : tcp_pkg

`default_nettype wire

// *** sim/tb.sv ***
/*
 * self-checking bench for the timer compare and pwm unit.
 * assumes the register map and one-wait-cycle avalon answer of tcp_pkg.
 */
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import tcp_pkg::*;

	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic timer_tick_i = 1'b0;
	logic [ADDR_W-1:0] avs_address_i = '0;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = '0;
	logic [3:0] avs_byteenable_i = 4'hf;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o;
	logic tp_out_o;
	logic tp_oe_o;
	logic compare_a_flag_o;
	logic compare_p_flag_o;
	int err_total = 0;
	int cmp_count = 0;

	// 125 mhz system clock
	always #4 clk_i = ~clk_i;

	tcp_timer_unit dut (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.timer_tick_i(timer_tick_i),
		.avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i),
		.avs_write_i(avs_write_i),
		.avs_byteenable_i(avs_byteenable_i),
		.avs_writedata_i(avs_writedata_i),
		.avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o),
		.tp_out_o(tp_out_o),
		.tp_oe_o(tp_oe_o),
		.compare_a_flag_o(compare_a_flag_o),
		.compare_p_flag_o(compare_p_flag_o)
	);

	// ------------------------------------------------------------------
	// shared helpers
	// ------------------------------------------------------------------
	task automatic complete_run();
		$display("mismatches %0d compares %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : complete_run

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	// request held until waitrequest is seen low at a rising edge; data taken at that edge
	task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= wr;
		avs_read_i <= ~wr;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (avs_waitrequest_o !== 1'b0 && n < 50);
		chk(n < 50, 1, "bus answer");
		q = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
	endtask : bus

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, exp, "read");
	endtask : rd

	// n back-to-back timer ticks
	task automatic tk(input int n);
		@(posedge clk_i);
		timer_tick_i <= 1'b1;
		repeat (n - 1) @(posedge clk_i);
		@(posedge clk_i);
		timer_tick_i <= 1'b0;
	endtask : tk

	// ticks, then lets the registered pin settle before judging it
	task automatic stp(input int n, input logic p);
		tk(n);
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		chk(tp_out_o, p, "pin");
	endtask : stp

	task automatic flg(input logic a, input logic p);
		chk({compare_p_flag_o, compare_a_flag_o}, {p, a}, "flags");
	endtask : flg

	// timer goes off before any mode or action change, flags cleared meanwhile
	task automatic setup(input logic [7:0] c2, input logic [15:0] a, input logic [7:0] p);
		wr(OFF_CTRL_ON, 32'h0);
		wr(OFF_STATUS, 32'h3);
		wr(OFF_TIMER_CONTROL_TWO, c2);
		wr(OFF_COMPARE_A_LOW_BYTE, a[7:0]);
		wr(OFF_COMPARE_A_HIGH_BYTE, a[15:8]);
		wr(OFF_COMPARE_P_TOP_BYTE, p);
		wr(OFF_CTRL_ON, 32'h8);
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
	endtask : setup

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task automatic t_regs();
		rd(OFF_COMPARE_A_LOW_BYTE, 32'h0);
		rd(OFF_COMPARE_A_HIGH_BYTE, 32'h0);
		rd(OFF_COMPARE_P_TOP_BYTE, 32'h0);
		wr(OFF_COMPARE_A_LOW_BYTE, 32'ha5);
		wr(OFF_COMPARE_A_HIGH_BYTE, 32'h5a);
		wr(OFF_COMPARE_P_TOP_BYTE, 32'hc3);
		// a write without the low byte lane must leave the register alone
		avs_byteenable_i <= 4'he;
		wr(OFF_COMPARE_P_TOP_BYTE, 32'h11);
		avs_byteenable_i <= 4'hf;
		rd(OFF_COMPARE_A_LOW_BYTE, 32'ha5);
		rd(OFF_COMPARE_A_HIGH_BYTE, 32'h5a);
		rd(OFF_COMPARE_P_TOP_BYTE, 32'hc3);
		rd(5'h1c, 32'h0);
	endtask : t_regs

	task automatic t_cmp();
		setup(8'h30, 16'h0010, 8'h01);
		chk(tp_oe_o, 1, "oe");
		chk(tp_out_o, 0, "pin start");
		stp(15, 0);
		flg(0, 0);
		stp(1, 1);
		flg(1, 0);
		stp(240, 1);
		flg(1, 1);
		rd(OFF_STATUS, 32'h7);
		wr(OFF_STATUS, 32'h3);
		stp(16, 0);
		flg(1, 0);
		setup(8'h0c, 16'h0010, 8'h01);
		chk(tp_out_o, 0, "pin inverted");
		stp(16, 0);
		flg(1, 0);
		setup(8'h18, 16'h0010, 8'h01);
		chk(tp_out_o, 1, "pin start");
		stp(16, 0);
	endtask : t_cmp

	// p below a yet only the a flag; a second a match proves the clear
	task automatic t_clr_a();
		setup(8'h21, 16'h0120, 8'h01);
		stp(288, 1);
		flg(1, 0);
		wr(OFF_STATUS, 32'h3);
		stp(288, 1);
		flg(1, 0);
	endtask : t_clr_a

	task automatic t_tmr();
		setup(8'hf0, 16'h0010, 8'h01);
		chk(tp_oe_o, 0, "oe");
		stp(256, 0);
		flg(1, 1);
	endtask : t_tmr

	task automatic t_pwm();
		setup(8'ha9, 16'h0040, 8'h01);
		chk(tp_out_o, 1, "pwm start");
		stp(64, 0);
		flg(1, 0);
		stp(192, 1);
		flg(1, 1);
		setup(8'hac, 16'h0040, 8'h01);
		chk(tp_out_o, 0, "pwm inverted");
		stp(64, 1);
		setup(8'h98, 16'h0040, 8'h01);
		stp(256, 1);
		flg(1, 1);
		setup(8'h88, 16'h0040, 8'h01);
		stp(256, 0);
		flg(1, 1);
		setup(8'ha8, 16'h0100, 8'h01);
		stp(255, 1);
		stp(2, 1);
		setup(8'hab, 16'h0180, 8'h01);
		stp(255, 1);
		stp(1, 0);
		stp(127, 0);
		stp(1, 1);
	endtask : t_pwm

	// ------------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------------
	initial
	begin
		repeat (6) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		t_regs();
		t_cmp();
		t_clr_a();
		t_tmr();
		t_pwm();
		complete_run();
	end

	// the whole run needs well under 10000 cycles
	initial
	begin
		#400000;
		err_total++;
		complete_run();
	end

endmodule : tb

`default_nettype wire
